// ===== verilog/mct_pkg.sv
// ----------------------------------------------------------------------
// Shared constants of the match/capture timer
// ----------------------------------------------------------------------
package mct_pkg;
    // Sizes
    localparam int NCH = 4;
    localparam int DW = 32;
    localparam int AW = 8;

    // Register byte offsets
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_COUNT = 8'h04;
    localparam logic [AW-1:0] ADDR_PRESCALE = 8'h08;
    localparam logic [AW-1:0] ADDR_PCOUNT = 8'h0C;
    localparam logic [AW-1:0] ADDR_MATCH_CTRL = 8'h10;
    localparam logic [AW-1:0] ADDR_CAP_CTRL = 8'h14;
    localparam logic [AW-1:0] ADDR_OUT_CTRL = 8'h18;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h1C;
    localparam logic [AW-1:0] ADDR_MASK = 8'h20;
    localparam logic [AW-1:0] ADDR_SHADOW_EN = 8'h24;
    localparam logic [AW-1:0] ADDR_MATCH0 = 8'h30;
    localparam logic [AW-1:0] ADDR_CAP0 = 8'h40;
    localparam logic [AW-1:0] ADDR_STEP = 8'h04;

    // Control register bits
    localparam int CTRL_EN = 0;
    localparam int CTRL_RST = 1;
    localparam int CTRL_EXT = 2;
    localparam int CTRL_W = 3;

    // Match control: four bits per channel
    localparam int MC_IRQ = 0;
    localparam int MC_RST = 1;
    localparam int MC_STOP = 2;
    localparam int MC_DMA = 3;
    localparam int MC_STRIDE = 4;

    // Capture control: three bits per channel
    localparam int CC_RISE = 0;
    localparam int CC_FALL = 1;
    localparam int CC_IRQ = 2;
    localparam int CC_STRIDE = 3;

    // Status and mask layout
    localparam int ST_MATCH = 0;
    localparam int ST_CAP = 4;
    localparam int ST_W = 8;

    // Reset and limit values
    localparam logic [DW-1:0] ZERO = 32'h0000_0000;
    localparam logic [DW-1:0] CNT_MAX = 32'hFFFF_FFFF;
    localparam logic [DW-1:0] ONE = 32'h0000_0001;

    // Bus slave states
    typedef enum logic [1:0] {
        MCT_BUS_IDLE = 2'b01,
        MCT_BUS_ACK = 2'b10
    } mct_bus_e;
endpackage : mct_pkg

// ===== verilog/mct_chan_if.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Link between the timer core and one match channel
// ----------------------------------------------------------------------
interface mct_chan_if;
    logic [31:0] count;
    logic [31:0] wr_data;
    logic wr;
    logic load;
    logic shadow_en;
    logic [31:0] active;
    logic [31:0] shadow;
    logic hit;

    modport ctl (output count, wr_data, wr, load, shadow_en,
                 input active, shadow, hit);
    modport chan (input count, wr_data, wr, load, shadow_en,
                  output active, shadow, hit);
endinterface : mct_chan_if

// ===== verilog/mct_match_chan.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// One match channel: shadow value, active value, comparator
// ----------------------------------------------------------------------
module mct_match_chan (
    input wire logic mclk,    // Timer clock
    input wire logic rst_n,   // Synchronised reset, active low
    mct_chan_if.chan ch       // Link to the timer core
);
    typedef struct packed {
        logic [31:0] shadow;
        logic [31:0] active;
    } mct_chan_s;

    mct_chan_s st_reg;
    mct_chan_s st_next;

    // Shadow takes writes; active follows at a period boundary
    always_comb begin
        st_next = st_reg;
        if (ch.wr) begin
            st_next.shadow = ch.wr_data;
        end
        if (ch.wr && !ch.shadow_en) begin
            st_next.active = ch.wr_data;   // Direct update when unbuffered
        end else if (ch.load) begin
            st_next.active = ch.wr ? ch.wr_data : st_reg.shadow;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Full-width compare against the active value
    assign ch.hit = (ch.count == st_reg.active);
    assign ch.active = st_reg.active;
    assign ch.shadow = st_reg.shadow;
endmodule : mct_match_chan

// ===== verilog/mct_timer.sv
`timescale 1ns/100ps
// Behaviour
// - 32-bit counter advanced through 32-bit prescaler
// - counts system clock or external clock edges
// - four matches raise interrupt or DMA request
// - match values are 32 bits, full compare
// - four captures snapshot count on input edge
// - capture interrupt selectable per channel
// - continuous match keeps counter running
// - stop match halts counter at value
// - reset match returns counter to zero
// - shadowed match values keep PWM glitch-free
// - four match outputs set low or high
module mct_timer (
    input wire logic mclk,                  // Timer clock, 125 MHz
    input wire logic nrst,                  // Async reset, active low
    input wire logic [7:0] avs_address,     // Byte address
    input wire logic avs_read,              // Read request
    input wire logic avs_write,             // Write request
    input wire logic [3:0] avs_byteenable,  // Write byte lanes
    input wire logic [31:0] avs_writedata,  // Write data
    output logic [31:0] avs_readdata,       // Read data
    output logic avs_waitrequest,           // Stall, high until answer
    input wire logic ext_clk_in,            // External count clock pin
    input wire logic [3:0] cap_in,          // Capture input pins
    output logic [3:0] match_out,           // Match output pins
    output logic [3:0] dma_req,             // Match DMA request pulses
    output logic irq                        // Level interrupt
);
    localparam int NCH = mct_pkg::NCH;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        mct_pkg::mct_bus_e bus;
        logic wait_q;
        logic [31:0] rdata;
        logic [mct_pkg::CTRL_W-1:0] ctrl;
        logic [31:0] count;
        logic [31:0] pcount;
        logic [31:0] prescale;
        logic [NCH*mct_pkg::MC_STRIDE-1:0] mctrl;
        logic [NCH*mct_pkg::CC_STRIDE-1:0] cctrl;
        logic [NCH-1:0] octrl;
        logic [mct_pkg::ST_W-1:0] status;
        logic [mct_pkg::ST_W-1:0] mask;
        logic [NCH-1:0] shen;
        logic [NCH-1:0][31:0] cap;
        logic [NCH-1:0] mout;
        logic [NCH-1:0] dma;
        logic irq;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic [NCH-1:0] cap_s1;
        logic [NCH-1:0] cap_s2;
        logic [NCH-1:0] cap_s3;
    } mct_state_s;

    mct_state_s st_reg;
    mct_state_s st_next;

    logic [NCH-1:0] hit_v;
    logic [NCH-1:0][31:0] active_v;
    logic [NCH-1:0][31:0] shadow_v;
    logic [NCH-1:0] mwr_v;
    logic load;

    // ------------------------------------------------------------------
    // Match channels
    // ------------------------------------------------------------------
    mct_chan_if chif[NCH] ();

    // One shadowed comparator per match register
    generate
        for (genvar g = 0; g < NCH; g++) begin : g_chan
            assign chif[g].count = st_reg.count;
            assign chif[g].wr_data = avs_writedata;
            assign chif[g].wr = mwr_v[g];
            assign chif[g].load = load;
            assign chif[g].shadow_en = st_reg.shen[g];
            assign hit_v[g] = chif[g].hit;
            assign active_v[g] = chif[g].active;
            assign shadow_v[g] = chif[g].shadow;
            mct_match_chan u_chan (
                .mclk(mclk),
                .rst_n(rst_n),
                .ch(chif[g].chan)
            );
        end
    endgenerate

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic wr_go;
    logic rd_go;
    logic src_evt;
    logic tick;
    logic any_rst;
    logic any_stop;
    logic ext_rise;
    logic [NCH-1:0] hits;
    logic [NCH-1:0] cap_evt;
    logic [mct_pkg::ST_W-1:0] st_set;
    logic [31:0] rmux;
    logic [7:0] a;
    logic [31:0] wm;

    // Counting, matches, captures and the register slave
    always_comb begin
        st_next = st_reg;
        a = avs_address;
        // Pin synchronisers and edge detection
        st_next.ext_s1 = ext_clk_in;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.ext_s3 = st_reg.ext_s2;
        st_next.cap_s1 = cap_in;
        st_next.cap_s2 = st_reg.cap_s1;
        st_next.cap_s3 = st_reg.cap_s2;
        ext_rise = st_reg.ext_s2 && !st_reg.ext_s3;

        // Bus accept strobes: the edge where waitrequest is low
        wr_go = avs_write && (st_reg.bus == mct_pkg::MCT_BUS_ACK);
        rd_go = avs_read && (st_reg.bus == mct_pkg::MCT_BUS_ACK);
        mwr_v = '0;
        for (int i = 0; i < NCH; i++) begin
            mwr_v[i] = wr_go && (a == mct_pkg::ADDR_MATCH0
                + 8'(i) * mct_pkg::ADDR_STEP) && (avs_byteenable != 4'h0);
        end

        // Source selection: internal clock or external edges
        src_evt = st_reg.ctrl[mct_pkg::CTRL_EN]
            && !st_reg.ctrl[mct_pkg::CTRL_RST]
            && (st_reg.ctrl[mct_pkg::CTRL_EXT] ? ext_rise : 1'b1);
        tick = src_evt && (st_reg.pcount == st_reg.prescale);
        if (!src_evt) begin
            st_next.pcount = st_reg.pcount;
        end else if (tick) begin
            st_next.pcount = mct_pkg::ZERO;
        end else begin
            st_next.pcount = st_reg.pcount + mct_pkg::ONE;
        end

        // Match actions on the tick where count equals the match value
        hits = hit_v & {NCH{tick}};
        any_rst = 1'b0;
        any_stop = 1'b0;
        st_set = '0;
        st_next.dma = '0;
        for (int i = 0; i < NCH; i++) begin
            any_rst = any_rst || (hits[i]
                && st_reg.mctrl[i*mct_pkg::MC_STRIDE + mct_pkg::MC_RST]);
            any_stop = any_stop || (hits[i]
                && st_reg.mctrl[i*mct_pkg::MC_STRIDE + mct_pkg::MC_STOP]);
            st_set[mct_pkg::ST_MATCH + i] = hits[i]
                && st_reg.mctrl[i*mct_pkg::MC_STRIDE + mct_pkg::MC_IRQ];
            st_next.dma[i] = hits[i]
                && st_reg.mctrl[i*mct_pkg::MC_STRIDE + mct_pkg::MC_DMA];
            if (hits[i]) begin
                st_next.mout[i] = st_reg.octrl[i];
            end
        end

        // Counter: hold, reset on match, or count and wrap
        if (st_reg.ctrl[mct_pkg::CTRL_RST]) begin
            st_next.count = mct_pkg::ZERO;
            st_next.pcount = mct_pkg::ZERO;
        end else if (tick && any_rst) begin
            st_next.count = mct_pkg::ZERO;
        end else if (tick && !any_stop) begin
            st_next.count = st_reg.count + mct_pkg::ONE;
        end
        if (any_stop) begin
            st_next.ctrl[mct_pkg::CTRL_EN] = 1'b0;
        end
        load = st_reg.ctrl[mct_pkg::CTRL_RST] || (tick && (any_rst
            || st_reg.count == mct_pkg::CNT_MAX));

        // Captures on selected edges of synchronised inputs
        for (int i = 0; i < NCH; i++) begin
            cap_evt[i] = (st_reg.cap_s2[i] && !st_reg.cap_s3[i]
                && st_reg.cctrl[i*mct_pkg::CC_STRIDE + mct_pkg::CC_RISE])
                || (!st_reg.cap_s2[i] && st_reg.cap_s3[i]
                && st_reg.cctrl[i*mct_pkg::CC_STRIDE + mct_pkg::CC_FALL]);
            if (cap_evt[i]) begin
                st_next.cap[i] = st_reg.count;
            end
            st_set[mct_pkg::ST_CAP + i] = cap_evt[i]
                && st_reg.cctrl[i*mct_pkg::CC_STRIDE + mct_pkg::CC_IRQ];
        end

        // Read multiplexer
        rmux = mct_pkg::ZERO;
        case (a)
            mct_pkg::ADDR_CTRL: rmux = 32'(st_reg.ctrl);
            mct_pkg::ADDR_COUNT: rmux = st_reg.count;
            mct_pkg::ADDR_PRESCALE: rmux = st_reg.prescale;
            mct_pkg::ADDR_PCOUNT: rmux = st_reg.pcount;
            mct_pkg::ADDR_MATCH_CTRL: rmux = 32'(st_reg.mctrl);
            mct_pkg::ADDR_CAP_CTRL: rmux = 32'(st_reg.cctrl);
            mct_pkg::ADDR_OUT_CTRL: rmux = 32'(st_reg.octrl);
            mct_pkg::ADDR_STATUS: rmux = 32'(st_reg.status);
            mct_pkg::ADDR_MASK: rmux = 32'(st_reg.mask);
            mct_pkg::ADDR_SHADOW_EN: rmux = 32'(st_reg.shen);
            default: begin
                for (int i = 0; i < NCH; i++) begin
                    if (a == mct_pkg::ADDR_MATCH0
                        + 8'(i) * mct_pkg::ADDR_STEP) begin
                        rmux = shadow_v[i];
                    end
                    if (a == mct_pkg::ADDR_CAP0
                        + 8'(i) * mct_pkg::ADDR_STEP) begin
                        rmux = st_reg.cap[i];
                    end
                end
            end
        endcase

        // Status: read clears only what was reported; a new event wins
        st_next.status = st_reg.status;
        if (rd_go && a == mct_pkg::ADDR_STATUS) begin
            st_next.status = st_reg.status
                & ~st_reg.rdata[mct_pkg::ST_W-1:0];
        end
        st_next.status = st_next.status | st_set;

        // Register writes, taken when waitrequest is low
        wm = be_merge(rmux, avs_writedata, avs_byteenable); // Old word merged
        if (wr_go) begin
            case (a)
                mct_pkg::ADDR_CTRL: st_next.ctrl = wm[mct_pkg::CTRL_W-1:0];
                mct_pkg::ADDR_COUNT: st_next.count = wm;
                mct_pkg::ADDR_PRESCALE: st_next.prescale = wm;
                mct_pkg::ADDR_MATCH_CTRL:
                    st_next.mctrl = wm[NCH*mct_pkg::MC_STRIDE-1:0];
                mct_pkg::ADDR_CAP_CTRL:
                    st_next.cctrl = wm[NCH*mct_pkg::CC_STRIDE-1:0];
                mct_pkg::ADDR_OUT_CTRL: st_next.octrl = wm[NCH-1:0];
                mct_pkg::ADDR_MASK: st_next.mask = wm[mct_pkg::ST_W-1:0];
                mct_pkg::ADDR_SHADOW_EN: st_next.shen = wm[NCH-1:0];
                default: ;
            endcase
        end

        // Bus handshake: one wait cycle, then answer
        case (st_reg.bus)
            mct_pkg::MCT_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    st_next.bus = mct_pkg::MCT_BUS_ACK;
                    st_next.wait_q = 1'b0;
                    st_next.rdata = avs_read ? rmux : st_reg.rdata;
                end
            end
            mct_pkg::MCT_BUS_ACK: begin
                st_next.bus = mct_pkg::MCT_BUS_IDLE;
                st_next.wait_q = 1'b1;
            end
            default: begin
                st_next.bus = mct_pkg::MCT_BUS_IDLE;
                st_next.wait_q = 1'b1;
            end
        endcase

        st_next.irq = |(st_next.status & st_next.mask);
    end

    // ------------------------------------------------------------------
    // State register and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.bus <= mct_pkg::MCT_BUS_IDLE;
            st_reg.wait_q <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata = st_reg.rdata;
    assign avs_waitrequest = st_reg.wait_q;
    assign match_out = st_reg.mout;
    assign dma_req = st_reg.dma;
    assign irq = st_reg.irq;
endmodule : mct_timer

// ===== testbench/mct_timer_properties.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checks of the match/capture timer
// ------------------------------------------------------------
module mct_timer_properties (
    input wire logic mclk, // Timer clock
    input wire logic nrst, // Reset, active low
    input wire logic [7:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [3:0] avs_byteenable, // Write lanes
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall
    input wire logic ext_clk_in, // External clock pin
    input wire logic [3:0] cap_in, // Capture pins
    input wire logic [3:0] match_out, // Match pins
    input wire logic [3:0] dma_req, // DMA pulses
    input wire logic irq // Interrupt
);
    logic [31:0] mc_reg;
    logic [3:0] oc_reg;
    logic [7:0] mask_reg;
    logic [3:0] dma_en;
    logic [3:0] lvl_ok;
    assign dma_en = {mc_reg[15], mc_reg[11], mc_reg[7], mc_reg[3]};
    // Copies of control words as the bus writes them (full lanes)
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mc_reg <= 32'h0000_0000;
            oc_reg <= 4'h0;
            mask_reg <= 8'h00;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address == mct_pkg::ADDR_MATCH_CTRL) begin
                mc_reg <= avs_writedata;
            end
            if (avs_address == mct_pkg::ADDR_OUT_CTRL) begin
                oc_reg <= avs_writedata[3:0];
            end
            if (avs_address == mct_pkg::ADDR_MASK) begin
                mask_reg <= avs_writedata[7:0];
            end
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    bus_ack_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low for more than one cycle");
    bus_ack_next_a: assert property
        ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("answer not one cycle after request");
    bus_ack_cause_a: assert property
        (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    rdata_hold_a: assert property
        ($changed(avs_readdata) |-> !avs_waitrequest && avs_read)
        else $error("read data moved outside a read answer");
    irq_masked_a: assert property
        (mask_reg == 8'h00 && $past(mask_reg) == 8'h00 |-> !irq)
        else $error("interrupt with all sources masked");
    dma_enabled_a: assert property
        ((dma_req & ~(dma_en | $past(dma_en))) == 4'h0)
        else $error("dma request on channel without dma enable");
    dma_pulse_a: assert property
        (dma_req != 4'h0 |=> (dma_req & $past(dma_req)) == 4'h0)
        else $error("dma request longer than one cycle");
    assign lvl_ok = ~(match_out ^ oc_reg);
    match_level_a: assert property
        (((match_out ^ $past(match_out)) & ~lvl_ok
          & (match_out ^ $past(oc_reg))) == 4'h0)
        else $error("match pin moved to a level not programmed");
endmodule : mct_timer_properties

bind mct_timer mct_timer_properties chk (
    .mclk(mclk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_clk_in(ext_clk_in), .cap_in(cap_in), .match_out(match_out),
    .dma_req(dma_req), .irq(irq));

// ===== testbench/mct_pin_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Far-side pins: external count clock and capture sources
// ------------------------------------------------------------
module mct_pin_model (
    input wire logic mclk, // Timer clock
    output logic ext_clk_in, // External count clock pin
    output logic [3:0] cap_in // Capture pins
);
    // Idle levels; the count clock stands low between bursts
    initial begin
        ext_clk_in = 1'b0;
        cap_in = 4'h0;
    end
    // Rising edges on the count pin, each level held three cycles
    task automatic ext_pulses(input int n);
        for (int k = 0; k < n; k++) begin
            repeat (3) @(posedge mclk);
            ext_clk_in <= 1'b1;
            repeat (3) @(posedge mclk);
            ext_clk_in <= 1'b0;
        end
    endtask : ext_pulses
    // One high pulse on a capture pin, long enough to be seen
    task automatic cap_pulse(input int ch);
        @(posedge mclk);
        cap_in[ch] <= 1'b1;
        repeat (3) @(posedge mclk);
        cap_in[ch] <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : cap_pulse
endmodule : mct_pin_model

// ===== testbench/mct_timer_bench.sv
`timescale 1ns/100ps
module mct_timer_bench;
    logic mclk;
    logic nrst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_clk_in;
    logic [3:0] cap_in;
    logic [3:0] match_out;
    logic [3:0] dma_req;
    logic irq;
    logic [31:0] rd;
    logic [31:0] p_val;
    logic [31:0] m_val;
    int err_count;
    int check_count;
    int n;
    localparam logic [7:0] m1_addr = mct_pkg::ADDR_MATCH0 + mct_pkg::ADDR_STEP;
    localparam logic [7:0] m2_addr = mct_pkg::ADDR_MATCH0 + 8'h08;

    mct_timer uut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_clk_in(ext_clk_in), .cap_in(cap_in), .match_out(match_out),
        .dma_req(dma_req), .irq(irq));
    mct_pin_model pm (.mclk(mclk), .ext_clk_in(ext_clk_in),
        .cap_in(cap_in));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Cycles from a counter reset to the next match
    function automatic logic [31:0] per(input logic [31:0] m,
                                        input logic [31:0] p);
        return (m + 32'h1) * (p + 32'h1);
    endfunction : per

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc

    // Wait for a dma pulse of a channel, or irq for ch 4
    task automatic wait_ev(input int ch, output int k);
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while ((ch == 4 ? !irq : !dma_req[ch]) && k < 9000);
        if (k >= 9000) begin
            chk(32'(k), 32'h0);
        end
    endtask : wait_ev

    // Clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        err_count = 0;
        check_count = 0;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        void'($urandom(32'h4BEB));
        p_val = 32'($urandom_range(4, 1));
        m_val = 32'($urandom_range(9, 3));
        // Reset values, unmapped and read-only places
        rdc(mct_pkg::ADDR_COUNT, 32'h0);
        wr(8'h2C, 32'hFFFF_FFFF);
        rdc(8'h2C, 32'h0);
        wr(mct_pkg::ADDR_STATUS, 32'hFF);
        rdc(mct_pkg::ADDR_STATUS, 32'h0);
        // Stop on match through the prescaler, with interrupt
        wr(mct_pkg::ADDR_PRESCALE, p_val);
        wr(mct_pkg::ADDR_MATCH0, m_val);
        wr(mct_pkg::ADDR_MATCH_CTRL, 32'h5);
        wr(mct_pkg::ADDR_MASK, 32'h1);
        wr(mct_pkg::ADDR_CTRL, 32'h1);
        wait_ev(4, n);
        chk(32'(n + 2 >= per(m_val, p_val)), 32'h1);
        chk(32'(n <= per(m_val, p_val) + 4), 32'h1);
        rdc(mct_pkg::ADDR_COUNT, m_val);
        rdc(mct_pkg::ADDR_CTRL, 32'h0);
        rdc(mct_pkg::ADDR_STATUS, 32'h1);
        rdc(mct_pkg::ADDR_STATUS, 32'h0);
        chk(32'(irq), 32'h0);
        // Captures of the halted count; channel 3 falls, no interrupt
        wr(mct_pkg::ADDR_MASK, 32'hF0);
        wr(mct_pkg::ADDR_CAP_CTRL, 32'h56D);
        for (int i = 0; i < 4; i++) begin
            pm.cap_pulse(i);
            rdc(mct_pkg::ADDR_CAP0 + 8'(4 * i), m_val);
            rdc(mct_pkg::ADDR_STATUS, i < 3 ? 32'h10 << i : 32'h0);
        end
        // Reset on match with dma and a match pin set high then low
        wr(mct_pkg::ADDR_CTRL, 32'h2);
        wr(mct_pkg::ADDR_MATCH_CTRL, 32'hA0);
        wr(mct_pkg::ADDR_OUT_CTRL, 32'h2);
        wr(m1_addr, m_val);
        wr(mct_pkg::ADDR_MASK, 32'h0);
        wr(mct_pkg::ADDR_CTRL, 32'h1);
        wait_ev(1, n);
        wait_ev(1, n);
        chk(32'(n), per(m_val, p_val));
        @(posedge mclk);
        chk(32'(match_out[1]), 32'h1);
        wr(mct_pkg::ADDR_OUT_CTRL, 32'h0);
        wait_ev(1, n);
        @(posedge mclk);
        chk(32'(match_out[1]), 32'h0);
        // Shadowed match value takes over after the next reset
        wr(mct_pkg::ADDR_SHADOW_EN, 32'h2);
        wr(m1_addr, m_val + 32'h3);
        rdc(m1_addr, m_val + 32'h3);
        wait_ev(1, n);
        wait_ev(1, n);
        chk(32'(n), per(m_val + 32'h3, p_val));
        // Continuous match: interrupt, counter keeps running
        wr(mct_pkg::ADDR_CTRL, 32'h2);
        wr(mct_pkg::ADDR_SHADOW_EN, 32'h0);
        wr(m2_addr, m_val);
        wr(mct_pkg::ADDR_MATCH_CTRL, 32'h100);
        wr(mct_pkg::ADDR_MASK, 32'h4);
        wr(mct_pkg::ADDR_CTRL, 32'h1);
        wait_ev(4, n);
        rdc(mct_pkg::ADDR_STATUS, 32'h4);
        repeat (8) @(posedge mclk);
        bus(1'b0, mct_pkg::ADDR_COUNT, 32'h0);
        chk(32'(rd > m_val), 32'h1);
        rdc(mct_pkg::ADDR_CTRL, 32'h1);
        // External clock counting, prescaler at zero
        wr(mct_pkg::ADDR_CTRL, 32'h2);
        wr(mct_pkg::ADDR_PRESCALE, 32'h0);
        wr(mct_pkg::ADDR_MATCH_CTRL, 32'h0);
        wr(mct_pkg::ADDR_CTRL, 32'h5);
        n = $urandom_range(9, 3);
        pm.ext_pulses(n);
        repeat (8) @(posedge mclk);
        rdc(mct_pkg::ADDR_COUNT, 32'(n));
        end_of_test();
    end
endmodule : mct_timer_bench
